// [design/laf_readout_framer.sv]
// Functional notes
// - three byte command, opcode nibble, start, end
// - resolution nibble decodes to 1, 2, 4, 8 bit
// - pixel indices clamped to 2..143
// - ascending, descending or single pixel selection
// - pixel 1 before, pixel 144 after selection
// - conversion done clears after first command byte
// - fixed 8-bit frame byte order and length
// - echo previous and current control bytes
// - status byte: resolution, mode, probe, version
// - wrapping frame counter, cleared by chip reset
// - 8-bit mode adds temperature and ADC tests
// - average of selected pixels only
// - CRC covers bytes zero through average
// - 4-bit mode packs two pixels per byte
// - 4-bit average uses four padded zeros
// - partial pixel byte MSB aligned, zero padded
// - low modes insert threshold byte at six
// - no code 11; average padded six/seven zeros
// - two-bit and one-bit threshold coding
// - CCITT polynomial primed with 0xFFFF
// - ignore readout while conversion done low
//
// The register offsets and the Avalon-MM register port were left to the implementer.
module laf_readout_framer
  import laf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe_n,
  output logic             conversion_done_out
);
  import laf_pkg::*;

  logic [7:0]    pix_mem [0:NUM_PIXELS-1];
  logic [2:0]    sync1, sync2, sync3, filt, filt_d;
  logic          sclk_rise, sclk_fall, cs_f, mosi_f, bus_ack;
  logic          normal_mode, dual_temp, int_pulse, chip_reset_pulse;
  logic [7:0]    thresh, pix_addr;
  logic [23:0]   prev_ctrl;
  logic [31:0]   test_vals, rd_mux;
  laf_link_type  link_st;
  laf_phase_type phase, next_phase;
  logic [2:0]    bit_cnt;
  logic [1:0]    cmd_idx, res_sel, dec_sel;
  logic [7:0]    rx_sh, rx_nx, s_raw, e_raw, sel_s, sel_e, sel_n;
  logic [7:0]    ob, shout, nb, hdr_byte, hdr_len, fcnt;
  logic [15:0]   crc;
  logic          cmd_done, dec_ok, accept, boundary, take, crc_upd, frame_end;
  logic [3:0]    bpp, pk_bits, bits_n;
  logic [7:0]    pk_idx, pk_cur, stage, pix_raw, code8, placed;
  logic          pk_full, pk_fill, pix_done, dv_run, dv_started;
  logic [15:0]   sum, quo, rem, r_sh;
  logic [4:0]    dv_cnt;

  function automatic logic [7:0] clamp_pix(input logic [7:0] p);
    clamp_pix = (p < PIX_MIN) ? PIX_MIN : ((p > PIX_MAX) ? PIX_MAX : p);
  endfunction

  // three stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1  <= SYNC_IDLE;
      sync2  <= SYNC_IDLE;
      sync3  <= SYNC_IDLE;
      filt   <= SYNC_IDLE;
      filt_d <= SYNC_IDLE;
    end else begin
      sync1  <= {sclk, cs_n, mosi};
      sync2  <= sync1;
      sync3  <= sync2;
      filt   <= (filt & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
      filt_d <= filt;
    end
  end

  assign cs_f      = filt[1];
  assign mosi_f    = filt[0];
  assign sclk_rise = filt[2] & ~filt_d[2] & ~cs_f;
  assign sclk_fall = ~filt[2] & filt_d[2] & ~cs_f;

  // avalon slave: one wait cycle, then the answer
  assign bus_ack = (avs_read | avs_write) & ~avs_waitrequest;

  always_comb begin
    case (avs_address)
      REG_CTRL:     rd_mux = {28'h0000000, dual_temp, normal_mode, 2'h0};
      REG_STATUS:   rd_mux = {14'h0000, res_sel, fcnt, 6'h00,
                              link_st == LINK_RUN, conversion_done_out};
      REG_PREV:     rd_mux = {8'h00, prev_ctrl};
      REG_THRESH:   rd_mux = {24'h000000, thresh};
      REG_TEST:     rd_mux = test_vals;
      REG_PIX_ADDR: rd_mux = {24'h000000, pix_addr};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      normal_mode     <= NORMAL_RESET;
      dual_temp       <= DUAL_TEMP_RESET;
      thresh          <= THRESH_RESET;
      prev_ctrl       <= PREV_RESET;
      test_vals       <= TEST_RESET;
      pix_addr        <= 8'h00;
      int_pulse       <= 1'b0;
      chip_reset_pulse <= 1'b0;
    end else begin
      int_pulse        <= 1'b0;
      chip_reset_pulse <= 1'b0;
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rd_mux;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (bus_ack & avs_write) begin
        case (avs_address)
          REG_CTRL: begin
            int_pulse   <= avs_writedata[CTRL_INT_DONE_BIT];
            chip_reset_pulse <= avs_writedata[CTRL_CHIP_RESET_BIT];
            normal_mode <= avs_writedata[CTRL_NORMAL_BIT];
            dual_temp   <= avs_writedata[CTRL_DUAL_TEMP_BIT];
            if (avs_writedata[CTRL_CHIP_RESET_BIT]) begin
              thresh <= THRESH_RESET;
            end
          end
          REG_PREV:     prev_ctrl <= avs_writedata[23:0];
          REG_THRESH:   thresh    <= avs_writedata[7:0];
          REG_TEST:     test_vals <= avs_writedata;
          REG_PIX_ADDR: pix_addr  <= avs_writedata[7:0];
          REG_PIX_DATA: pix_addr  <= 8'(pix_addr + 8'h01);
          default: ;
        endcase
      end
    end
  end

  // pixel store stands in for the converter; software loads it before readout
  always_ff @(posedge mclk) begin
    if (bus_ack & avs_write & (avs_address == REG_PIX_DATA) & (pix_addr < PIX_LAST)) begin
      pix_mem[pix_addr] <= avs_writedata[7:0];
    end
  end

  // command byte decode
  assign rx_nx = {rx_sh[6:0], mosi_f};
  always_comb begin
    dec_ok  = 1'b1;
    dec_sel = RES_SEL_8B;
    case (rx_nx[3:0])
      RES_CODE_1B: dec_sel = RES_SEL_1B;
      RES_CODE_2B: dec_sel = RES_SEL_2B;
      RES_CODE_4B: dec_sel = RES_SEL_4B;
      RES_CODE_8B: dec_sel = RES_SEL_8B;
      default:     dec_ok  = 1'b0;
    endcase
  end

  // a readout while conversion is not done is treated as foreign and skipped
  assign accept = sclk_rise & (bit_cnt == 3'h7) & (link_st == LINK_IDLE) &
                  (rx_nx[7:4] == READOUT_OPCODE) & dec_ok & conversion_done_out;
  assign boundary  = sclk_fall & (bit_cnt == 3'h0) & (link_st == LINK_RUN);
  assign frame_end = boundary & (phase == PH_DONE);

  always_comb begin
    case (res_sel)
      RES_SEL_1B: begin bpp = 4'h1; hdr_len = HDR_LEN_LOW; end
      RES_SEL_2B: begin bpp = 4'h2; hdr_len = HDR_LEN_LOW; end
      RES_SEL_4B: begin bpp = 4'h4; hdr_len = HDR_LEN_4B;  end
      default:    begin bpp = 4'h8; hdr_len = HDR_LEN_8B;  end
    endcase
  end

  // header bytes; layout shifts by one where the threshold byte is inserted
  always_comb begin
    logic [7:0] status_b;
    logic [7:0] k;
    status_b = {res_sel, normal_mode, dual_temp, VERSION_CODE};
    k        = ob;
    hdr_byte = 8'h00;
    if ((res_sel == RES_SEL_1B || res_sel == RES_SEL_2B) && ob >= 8'h06) begin
      k = 8'(ob - 8'h01);
      if (ob == 8'h06) begin
        hdr_byte = thresh;
      end
    end
    if (!((res_sel == RES_SEL_1B || res_sel == RES_SEL_2B) && ob == 8'h06)) begin
      case (k)
        8'h00:   hdr_byte = SANITY_BYTE;
        8'h01:   hdr_byte = prev_ctrl[23:16];
        8'h02:   hdr_byte = prev_ctrl[15:8];
        8'h03:   hdr_byte = prev_ctrl[7:0];
        8'h04:   hdr_byte = s_raw;
        8'h05:   hdr_byte = e_raw;
        8'h06:   hdr_byte = status_b;
        8'h07:   hdr_byte = fcnt;
        8'h08:   hdr_byte = test_vals[7:0];
        8'h09:   hdr_byte = test_vals[15:8];
        8'h0A:   hdr_byte = test_vals[23:16];
        8'h0B:   hdr_byte = test_vals[31:24];
        default: hdr_byte = 8'h00;
      endcase
    end
  end

  // byte to load at the next byte boundary
  always_comb begin
    nb         = 8'h00;
    next_phase = phase;
    take       = 1'b0;
    crc_upd    = 1'b0;
    case (phase)
      PH_HDR: begin
        nb      = hdr_byte;
        crc_upd = 1'b1;
        if (8'(ob + 8'h01) == hdr_len) begin
          next_phase = PH_PIX;
        end
      end
      PH_PIX: begin
        crc_upd = 1'b1;
        if (pk_full) begin
          nb   = stage;
          take = boundary;
        end else begin
          nb         = quo[7:0];
          next_phase = PH_CRC1;
        end
      end
      PH_CRC1: begin
        nb         = crc[15:8];
        next_phase = PH_CRC2;
      end
      PH_CRC2: begin
        nb         = crc[7:0];
        next_phase = PH_DONE;
      end
      PH_DONE:  next_phase = PH_TAIL;
      default:  next_phase = PH_TAIL;
    endcase
  end

  // spi receive and frame shifter, mode 0: sample on rise, shift on fall
  always_ff @(posedge mclk) begin
    if (rst || cs_f) begin
      link_st  <= LINK_IDLE;
      bit_cnt  <= 3'h0;
      rx_sh    <= 8'h00;
      cmd_idx  <= 2'h0;
      cmd_done <= 1'b0;
      phase    <= PH_HDR;
      ob       <= 8'h00;
      shout    <= 8'h00;
      crc      <= CRC_INIT;
      if (rst) begin
        res_sel <= RES_SEL_8B;
        s_raw   <= 8'h00;
        e_raw   <= 8'h00;
        sel_s   <= PIX_MIN;
        sel_e   <= PIX_MIN;
        sel_n   <= 8'h01;
      end
    end else begin
      if (sclk_rise) begin
        rx_sh   <= rx_nx;
        bit_cnt <= 3'(bit_cnt + 3'h1);
        if (bit_cnt == 3'h7) begin
          if (accept) begin
            link_st <= LINK_RUN;
            res_sel <= dec_sel;
            cmd_idx <= 2'h1;
            crc     <= CRC_INIT;
          end else if (link_st == LINK_IDLE) begin
            link_st <= LINK_SKIP;
          end else if (link_st == LINK_RUN && cmd_idx == 2'h1) begin
            s_raw   <= rx_nx;
            cmd_idx <= 2'h2;
          end else if (link_st == LINK_RUN && cmd_idx == 2'h2) begin
            e_raw    <= rx_nx;
            sel_s    <= clamp_pix(s_raw);
            sel_e    <= clamp_pix(rx_nx);
            sel_n    <= (clamp_pix(s_raw) > clamp_pix(rx_nx)) ?
                        8'(clamp_pix(s_raw) - clamp_pix(rx_nx) + 8'h01) :
                        8'(clamp_pix(rx_nx) - clamp_pix(s_raw) + 8'h01);
            cmd_done <= 1'b1;
            cmd_idx  <= 2'h3;
          end
        end
      end
      if (boundary) begin
        shout <= nb;
        phase <= next_phase;
        if (phase == PH_HDR) begin
          ob <= 8'(ob + 8'h01);
        end
        if (crc_upd) begin
          crc <= laf_crc_byte(crc, nb);
        end
      end else if (sclk_fall) begin
        shout <= {shout[6:0], 1'b0};
      end
    end
  end

  // set by the end of integration wins over the clear from an accepted command
  always_ff @(posedge mclk) begin
    if (rst) begin
      conversion_done_out <= 1'b0;
    end else if (int_pulse) begin
      conversion_done_out <= 1'b1;
    end else if (accept) begin
      conversion_done_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || chip_reset_pulse) begin
      fcnt <= FCNT_RESET;
    end else if (frame_end) begin
      fcnt <= 8'(fcnt + 8'h01);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      miso      <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso      <= shout[7];
      miso_oe_n <= cs_f;
    end
  end

  // pixel packer: fetches one pixel per clock into a staging byte
  assign pix_raw = pix_mem[8'(pk_cur - 8'h01)];
  assign bits_n  = 4'(pk_bits + bpp);
  assign pk_fill = cmd_done & ~pk_full & ~take & (pk_idx <= 8'(sel_n + 8'h01));
  assign placed  = 8'(code8 << 4'(BYTE_BITS - bits_n));
  assign pix_done = (pk_idx == 8'(sel_n + 8'h02));

  always_comb begin
    logic [3:0] lo_eff;
    lo_eff = (thresh[3:0] > thresh[7:4]) ? thresh[7:4] : thresh[3:0];
    case (res_sel)
      RES_SEL_1B: code8 = {7'h00, pix_raw[7:4] > thresh[7:4]};
      RES_SEL_2B: code8 = (pix_raw[7:4] > thresh[7:4]) ? 8'h02 :
                          ((pix_raw[7:4] < lo_eff) ? 8'h00 : 8'h01);
      RES_SEL_4B: code8 = {4'h0, pix_raw[7:4]};
      default:    code8 = pix_raw;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst || !cmd_done) begin
      pk_idx  <= 8'h00;
      pk_cur  <= PIX_FIRST;
      stage   <= 8'h00;
      pk_bits <= 4'h0;
      pk_full <= 1'b0;
      sum     <= 16'h0000;
    end else if (take) begin
      stage   <= 8'h00;
      pk_full <= 1'b0;
    end else if (pk_fill) begin
      stage  <= stage | placed;
      pk_idx <= 8'(pk_idx + 8'h01);
      if (pk_idx != 8'h00 && pk_idx <= sel_n) begin
        sum <= 16'(sum + 16'(code8 << 4'(BYTE_BITS - bpp)));
      end
      if (pk_idx == 8'h00) begin
        pk_cur <= sel_s;
      end else if (pk_idx == sel_n) begin
        pk_cur <= PIX_LAST;
      end else if (sel_s <= sel_e) begin
        pk_cur <= 8'(pk_cur + 8'h01);
      end else begin
        pk_cur <= 8'(pk_cur - 8'h01);
      end
      if (bits_n == BYTE_BITS || pk_idx == 8'(sel_n + 8'h01)) begin
        pk_full <= 1'b1;
        pk_bits <= 4'h0;
      end else begin
        pk_bits <= bits_n;
      end
    end
  end

  // restoring divider for the average, started once the last pixel is in
  assign dv_run  = dv_started & (dv_cnt != 5'h00);
  assign r_sh    = {rem[14:0], quo[15]};

  always_ff @(posedge mclk) begin
    if (rst || !cmd_done) begin
      dv_started <= 1'b0;
      dv_cnt     <= 5'h00;
      quo        <= 16'h0000;
      rem        <= 16'h0000;
    end else if (!dv_started && pix_done) begin
      dv_started <= 1'b1;
      dv_cnt     <= DIV_STEPS;
      quo        <= sum;
      rem        <= 16'h0000;
    end else if (dv_run) begin
      dv_cnt <= 5'(dv_cnt - 5'h01);
      if (r_sh >= {8'h00, sel_n}) begin
        rem <= 16'(r_sh - {8'h00, sel_n});
        quo <= {quo[14:0], 1'b1};
      end else begin
        rem <= r_sh;
        quo <= {quo[14:0], 1'b0};
      end
    end
  end

endmodule

// [design/laf_pkg.sv]
package laf_pkg;
  // register byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_PREV     = 8'h08;
  localparam logic [7:0] REG_THRESH   = 8'h0C;
  localparam logic [7:0] REG_TEST     = 8'h10;
  localparam logic [7:0] REG_PIX_ADDR = 8'h14;
  localparam logic [7:0] REG_PIX_DATA = 8'h18;
  // control register fields
  localparam int CTRL_INT_DONE_BIT   = 0;
  localparam int CTRL_CHIP_RESET_BIT = 1;
  localparam int CTRL_NORMAL_BIT     = 2;
  localparam int CTRL_DUAL_TEMP_BIT  = 3;
  localparam logic       NORMAL_RESET    = 1'b1;
  localparam logic       DUAL_TEMP_RESET = 1'b0;
  localparam logic [7:0] THRESH_RESET    = 8'hB3;
  localparam logic [23:0] PREV_RESET     = 24'h000000;
  localparam logic [31:0] TEST_RESET     = 32'h00000000;
  localparam logic [7:0] FCNT_RESET      = 8'h00;
  // readout command decoding
  localparam logic [3:0] READOUT_OPCODE = 4'h9;
  localparam logic [3:0] RES_CODE_1B = 4'hC;
  localparam logic [3:0] RES_CODE_2B = 4'h6;
  localparam logic [3:0] RES_CODE_4B = 4'h3;
  localparam logic [3:0] RES_CODE_8B = 4'h9;
  // resolution as reported in the status byte
  localparam logic [1:0] RES_SEL_1B = 2'h0;
  localparam logic [1:0] RES_SEL_2B = 2'h1;
  localparam logic [1:0] RES_SEL_4B = 2'h2;
  localparam logic [1:0] RES_SEL_8B = 2'h3;
  // pixel geometry
  localparam int         NUM_PIXELS = 144;
  localparam logic [7:0] PIX_FIRST  = 8'h01;
  localparam logic [7:0] PIX_LAST   = 8'h90;
  localparam logic [7:0] PIX_MIN    = 8'h02;
  localparam logic [7:0] PIX_MAX    = 8'h8F;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  // header lengths per resolution
  localparam logic [7:0] HDR_LEN_8B  = 8'h0C;
  localparam logic [7:0] HDR_LEN_4B  = 8'h08;
  localparam logic [7:0] HDR_LEN_LOW = 8'h09;
  // arbitrary neutral identity values
  localparam logic [7:0] SANITY_BYTE  = 8'hA5;
  localparam logic [3:0] VERSION_CODE = 4'h5;
  // synchroniser idle value, order {sclk, cs_n, mosi}
  localparam logic [2:0] SYNC_IDLE = 3'h2;
  localparam logic [4:0] DIV_STEPS = 5'h10;
  // crc
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] CRC_PRIME = 16'hFFFF;
  function automatic logic [15:0] laf_crc_bit(input logic [15:0] c, input logic b);
    laf_crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction
  function automatic logic [15:0] laf_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) r = laf_crc_bit(r, d[i]);
    laf_crc_byte = r;
  endfunction
  localparam logic [15:0] CRC_INIT =
    laf_crc_byte(laf_crc_byte(16'h0000, CRC_PRIME[15:8]), CRC_PRIME[7:0]);
  typedef enum logic [1:0] {LINK_IDLE, LINK_SKIP, LINK_RUN} laf_link_type;
  typedef enum logic [2:0] {PH_HDR, PH_PIX, PH_CRC1, PH_CRC2, PH_DONE, PH_TAIL} laf_phase_type;
endpackage

// [sim/laf_readout_framer_assertions.sv]
module laf_readout_framer_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic conversion_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q;
  logic [3:0] rise_cnt;
  logic [3:0] fall_age;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  always_ff @(posedge mclk) sclk_q <= sclk;
  always_ff @(posedge mclk) begin
    if (rst || cs_n) rise_cnt <= 4'h0;
    else if (sclk && !sclk_q && rise_cnt != 4'hF) rise_cnt <= rise_cnt + 4'h1;
  end
  // saturates so a parked clock never wraps back into the window
  always_ff @(posedge mclk) begin
    if (rst) fall_age <= 4'hF;
    else if (!sclk && sclk_q) fall_age <= 4'h0;
    else if (fall_age != 4'hF) fall_age <= fall_age + 4'h1;
  end
  sequence s_access;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_reset_state: assert property ($fell(rst) |-> avs_waitrequest && !conversion_done_out
    && miso_oe_n && !miso) else $error("outputs not idle after reset");
  a_bus_answer: assert property (s_access |=> s_answer)
    else $error("bus answer not one cycle");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest low without request");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] miso_oe_n)
    else $error("miso not released");
  a_oe_drive: assert property ($fell(cs_n) |-> ##[1:6] !miso_oe_n)
    else $error("miso not driven");
  a_miso_idle: assert property (cs_n [*8] |-> !miso && miso_oe_n)
    else $error("miso active while deselected");
  a_done_fall: assert property ($fell(conversion_done_out) |-> rise_cnt == 4'h8 && !cs_n)
    else $error("done cleared at wrong bit");
  a_done_set: assert property ($rose(conversion_done_out) |->
    $past(avs_write && !avs_waitrequest) || $past(avs_write && !avs_waitrequest, 2))
    else $error("done set without control write");
  a_miso_timing: assert property ($changed(miso) && !miso_oe_n |->
    fall_age >= 4'h1 && fall_age <= 4'h5) else $error("miso moved off the falling edge");
endmodule

bind laf_readout_framer laf_readout_framer_assertions i_chk (
  .mclk(mclk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .sclk(sclk), .cs_n(cs_n), .miso(miso),
  .miso_oe_n(miso_oe_n), .conversion_done_out(conversion_done_out)
);

// [sim/laf_spi_host.sv]
module laf_spi_host (
  input  wire logic mclk,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic active = 1'b0;
  logic mosi_q = 1'b0;
  logic idle_pat = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // a released line toggles so a stale bit is never taken for data
  always_ff @(posedge mclk) idle_pat <= ~idle_pat;
  assign mosi = active ? mosi_q : idle_pat;
  task automatic open_frame();
    @(posedge mclk);
    cs_n <= 1'b0;
    active <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
  // pauses only between bytes, clock parked low; sampled late for sync lag
  task automatic xfer(input logic [7:0] tx, input int gap, output logic [7:0] rx);
    repeat (gap * 8) @(posedge mclk);
    for (int i = 7; i >= 0; i--) begin
      mosi_q <= tx[i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      rx[i] = miso;
      sclk <= 1'b0;
    end
  endtask
  task automatic close_frame();
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    active <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// [sim/laf_readout_framer_tb.sv]
module laf_readout_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import laf_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe_n;
  logic        conversion_done_out;
  int          failures = 0;
  int          comparisons = 0;
  int          seed = 32'h6BFA;
  logic [7:0]  pix [144];
  logic [7:0]  exp_q [$];
  logic [23:0] prev;
  logic [31:0] test;
  logic [7:0]  thr = 8'hB3;
  logic [7:0]  fcnt = 8'h00;
  logic        normal;
  logic        dual;
  logic [31:0] q;

  laf_readout_framer i_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .conversion_done_out(conversion_done_out));
  laf_spi_host i_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      $display("[ERR] %0t bus timeout", $time);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic void build(input logic [3:0] code, input logic [7:0] s,
                                input logic [7:0] e);
    int         bpp, cs, ce, sum, acc, nb, cd;
    int         idx [$];
    logic [15:0] c;
    logic [7:0] v;
    logic [7:0] stream [$];
    bpp = (code == RES_CODE_1B) ? 1 : (code == RES_CODE_2B) ? 2 : (code == RES_CODE_4B) ? 4 : 8;
    cs = (s < 2) ? 2 : (s > 143) ? 143 : s;
    ce = (e < 2) ? 2 : (e > 143) ? 143 : e;
    idx = {1};
    for (int p = cs; p != ce; p += (cs < ce) ? 1 : -1) idx.push_back(p);
    idx.push_back(ce);
    idx.push_back(144);
    exp_q = {SANITY_BYTE, prev[23:16], prev[15:8], prev[7:0], s, e};
    if (bpp < 4) exp_q.push_back(thr);
    exp_q.push_back({2'($clog2(bpp)), normal, dual, VERSION_CODE});
    exp_q.push_back(fcnt);
    if (bpp == 8) exp_q = {exp_q, test[7:0], test[15:8], test[23:16], test[31:24]};
    sum = 0;
    acc = 0;
    nb = 0;
    foreach (idx[k]) begin
      v = pix[idx[k] - 1];
      cd = (bpp == 8) ? v : (bpp == 4) ? v[7:4] : (v[7:4] > thr[7:4]) ? bpp
         : (bpp == 2 && v[7:4] > thr[3:0]) ? 1 : 0;
      if (k > 0 && k < idx.size() - 1) sum += cd << (8 - bpp);
      acc = (acc << bpp) | cd;
      nb += bpp;
      if (nb == 8) begin
        exp_q.push_back(8'(acc));
        acc = 0;
        nb = 0;
      end
    end
    if (nb > 0) exp_q.push_back(8'(acc << (8 - nb)));
    exp_q.push_back(8'(sum / (idx.size() - 2)));
    c = 16'h0000;
    stream = {8'hFF, 8'hFF, exp_q};
    foreach (stream[j]) begin
      for (int b = 7; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ stream[j][b]) ? 16'h1021 : 16'h0000);
      end
    end
    exp_q = {exp_q, c[15:8], c[7:0], 8'h00};
  endfunction

  task automatic frame(input logic [3:0] code, input logic [7:0] s, input logic [7:0] e);
    logic [7:0] rx;
    int         gap;
    normal = 1'($random(seed));
    dual = 1'($random(seed));
    bus(1'b1, REG_CTRL, {28'h0, dual, normal, 2'b01});
    repeat (3) @(posedge mclk);
    check(conversion_done_out, 1'b1, "done set");
    build(code, s, e);
    i_host.open_frame();
    for (int k = 0; k <= exp_q.size(); k++) begin
      gap = (k > 3) ? ($random(seed) & 1) : 0;
      i_host.xfer((k == 0) ? {READOUT_OPCODE, code} : (k == 1) ? s : (k == 2) ? e : 8'h00,
                  gap, rx);
      if (k == 1) check(conversion_done_out, 1'b0, "done clear");
      if (k > 0) check(rx, exp_q[k - 1], "frame byte");
    end
    i_host.close_frame();
    fcnt++;
    $display("test frame %h %h %h done", code, s, e);
  endtask

  task automatic refused(input logic [3:0] code, input logic done);
    logic [7:0] rx;
    if (done) bus(1'b1, REG_CTRL, 32'h5);
    i_host.open_frame();
    for (int k = 0; k < 4; k++) begin
      i_host.xfer((k == 0) ? {READOUT_OPCODE, code} : 8'h02, 0, rx);
      check(rx, 8'h00, "silent");
    end
    i_host.close_frame();
    check(conversion_done_out, done, "done kept");
    $display("test refused %h done", code);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    bus(1'b0, REG_STATUS, 32'h0);
    check(q[15:0], 16'h0000, "status reset");
    bus(1'b0, REG_THRESH, 32'h0);
    check(q[7:0], 8'hB3, "threshold reset");
    bus(1'b0, REG_CTRL, 32'h0);
    check(q[3:2], 2'b01, "control reset");
    bus(1'b1, 8'h1C, 32'hFFFFFFFF);
    bus(1'b0, 8'h1C, 32'h0);
    check(q, 32'h0, "unmapped");
    prev = 24'($random(seed));
    test = $random(seed);
    bus(1'b1, REG_PREV, {8'h00, prev});
    bus(1'b1, REG_TEST, test);
    bus(1'b1, REG_THRESH, 32'h5A);
    bus(1'b0, REG_PREV, 32'h0);
    check(q[23:0], prev, "prev readback");
    bus(1'b0, REG_TEST, 32'h0);
    check(q, test, "test readback");
    bus(1'b0, REG_THRESH, 32'h0);
    check(q[7:0], 8'h5A, "threshold write");
    bus(1'b1, REG_CTRL, 32'h6);
    bus(1'b0, REG_THRESH, 32'h0);
    check(q[7:0], 8'hB3, "threshold after chip reset");
    $display("test registers done");
    bus(1'b1, REG_PIX_ADDR, 32'h0);
    // nibbles equal to a threshold are steered away; the tie is not defined
    foreach (pix[i]) begin
      pix[i] = 8'($random(seed));
      if (pix[i][7:4] == 4'h3 || pix[i][7:4] == 4'hB) pix[i][4] = ~pix[i][4];
      bus(1'b1, REG_PIX_DATA, {24'h0, pix[i]});
    end
    frame(RES_CODE_8B, 8'h02, 8'h8F);
    frame(RES_CODE_4B, 8'h05, 8'h09);
    frame(RES_CODE_4B, 8'h0A, 8'h03);
    frame(RES_CODE_2B, 8'h00, 8'hC8);
    frame(RES_CODE_1B, 8'h07, 8'h07);
    frame(RES_CODE_8B, 8'hFF, 8'h8C);
    frame(RES_CODE_2B, 8'h10, 8'h0E);
    bus(1'b0, REG_STATUS, 32'h0);
    check(q[15:0], {fcnt, 8'h00}, "counter advanced");
    refused(RES_CODE_8B, 1'b0);
    refused(4'h5, 1'b1);
    bus(1'b1, REG_CTRL, 32'h6);
    fcnt = 8'h00;
    frame(RES_CODE_1B, 8'h01, 8'h0C);
    print_verdict();
  end
endmodule
